// [hw/mmc_consts.svh]
// Purpose: constants for the magnetometer measurement control
// Assumes: 100 MHz system clock, I2C clock as second domain
// Notes: offsets, reset values and timing counts
// Notes on behaviour
// - Data-ready idles high, drives low 250 us per result update.
// - Answer at one fixed 7-bit slave address, standard I2C.
// - Standard or fast mode only; no high-speed mode.
// - Device is slave only; master drives every transaction.
// - Register access from master served ahead of measurement.
// - Each measurement fires a set strap pulse and reads, then a reset strap pulse and reads again.
// - Output per axis is half of set minus reset reading.
// - Configuration bits enable self test bias and its polarity.
// - Operating mode selected by the mode register contents.
// - Sequencing runs from the internal clock, not the bus clock.
// - After power-up the device is in single-measurement mode.
// - Single mode: measure once, update, then rewrite mode to idle.
// - Continuous mode repeats at selected rate, overwriting results.
// - Address pointer wraps from last data byte to first.
`ifndef MMC_CONSTS_SVH
`define MMC_CONSTS_SVH
`define MMC_DW          16
`define MMC_I2C_ADDR    7'h1E
`define MMC_A_CRA       8'h00
`define MMC_A_CRB       8'h01
`define MMC_A_MODE      8'h02
`define MMC_A_DFIRST    8'h03
`define MMC_A_DLAST     8'h08
`define MMC_A_STAT      8'h09
`define MMC_A_IDA       8'h0A
`define MMC_A_IDB       8'h0B
`define MMC_A_IDC       8'h0C
`define MMC_CRA_RST     8'h70
`define MMC_CRB_RST     8'h20
`define MMC_MODE_RST    8'h01
`define MMC_CLK_NS      10
`define MMC_DATA_READY_N_US     250
`define MMC_DATA_READY_N_CYC    ((`MMC_DATA_READY_N_US * 1000) / `MMC_CLK_NS)
`define MMC_STRAP_NS    500
`define MMC_STRAP_CYC   ((`MMC_STRAP_NS + `MMC_CLK_NS - 1) / `MMC_CLK_NS)
`define MMC_ODR75_HZ    75
`define MMC_RATE75_CYC  (1000000000 / (`MMC_ODR75_HZ * `MMC_CLK_NS))
`endif

// [hw/mmc_pkg.sv]
// Purpose: types shared by the measurement control
// Assumes: constants header on the include path
// Notes: mode and bias codes follow the mode and config registers
`include "mmc_consts.svh"
package mmc_pkg;
    typedef enum logic [1:0] {
        MODE_CONT = 2'h0, MODE_SINGLE = 2'h1, MODE_IDLE = 2'h3
    } mmc_mode_t;
    typedef enum logic [1:0] {
        MS_NORM = 2'h0, MS_POS = 2'h1, MS_NEG = 2'h2
    } mmc_ms_t;
    typedef enum logic [2:0] {
        M_IDLE = 3'h0, M_SET = 3'h1, M_CS = 3'h2, M_RST = 3'h3,
        M_CR = 3'h4, M_WRITE = 3'h5, M_WAIT = 3'h6
    } mmc_mst_t;
    typedef enum logic [2:0] {
        L_IDLE = 3'h0, L_ADDR = 3'h1, L_ACKA = 3'h2, L_PTR = 3'h3,
        L_ACKP = 3'h4, L_WR = 3'h5, L_ACKW = 3'h6, L_RD = 3'h7
    } mmc_lst_t;
    typedef struct packed {
        logic [2:0][`MMC_DW-1:0] ax;
    } mmc_res_t;
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] ms;
        logic [2:0] rate;
    } mmc_cfg_t;
endpackage

// [hw/mmc_top.sv]
// Purpose: measurement sequencing and I2C slave of the magnetometer
// Assumes: link logic clocked by scl_in; sequencing by clk_in
// Notes: sda is open drain, oe high pulls the line low
`timescale 1ns/100ps
`include "mmc_consts.svh"
module mmc_top
    import mmc_pkg::*;
#(
    parameter int         DATA_READY_N_CYC = `MMC_DATA_READY_N_CYC,
    parameter int         RATE_CYC = `MMC_RATE75_CYC,
    parameter logic [7:0] ID_A     = 8'hA1, // Arbitrary identity value
    parameter logic [7:0] ID_B     = 8'hB2, // Arbitrary identity value
    parameter logic [7:0] ID_C     = 8'hC3  // Arbitrary identity value
)(
    // System clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rst_n_in,
    // I2C link
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_out_out,
    output logic                          sda_oe_out,
    // Sensor front end
    output logic                          strap_pos_node_out,
    output logic                          strap_drive_node_out,
    output logic                          bias_pos_out,
    output logic                          bias_neg_out,
    output logic                          conv_req_out,
    output logic [1:0]                    conv_axis_out,
    input  wire logic                     conv_valid_in,
    input  wire logic [`MMC_DW-1:0]       conv_data_in,
    // Completion
    output logic                          data_ready_n_out
);

    // Pointer advance, wrapping inside the data bytes
    function automatic logic [7:0] nxt_ptr(input logic [7:0] p);
        if (p == `MMC_A_DLAST)
            return `MMC_A_DFIRST;
        else if (p >= `MMC_A_IDC)
            return `MMC_A_CRA;
        else
            return p + 8'h01;
    endfunction

    // Read mux; unmapped addresses read zero
    function automatic logic [7:0] rd_byte(input logic [7:0] p,
        input logic [7:0] a, input logic [7:0] b, input logic [7:0] m,
        input mmc_res_t d);
        logic [3:0] i;
        i = p[3:0] - 4'h3;
        case (p)
            `MMC_A_CRA:  return a;
            `MMC_A_CRB:  return b;
            `MMC_A_MODE: return m;
            `MMC_A_IDA:  return ID_A;
            `MMC_A_IDB:  return ID_B;
            `MMC_A_IDC:  return ID_C;
            default: begin
                if (p >= `MMC_A_DFIRST && p <= `MMC_A_DLAST)
                    return i[0] ? d.ax[i[2:1]][7:0] : d.ax[i[2:1]][15:8];
                return 8'h00;
            end
        endcase
    endfunction

    // Offset-cancelled half difference of set and reset readings
    function automatic logic [`MMC_DW-1:0] half_dif(
        input logic [`MMC_DW-1:0] s, input logic [`MMC_DW-1:0] r);
        logic [`MMC_DW:0] d;
        d = {s[`MMC_DW-1], s} - {r[`MMC_DW-1], r};
        return d[`MMC_DW:1];
    endfunction

    // Continuous period from the rate code, in half steps of 75 Hz
    function automatic logic [31:0] rate_cyc(input logic [2:0] c);
        logic [31:0] h;
        case (c)
            3'h0:    h = 32'h0C8;
            3'h1:    h = 32'h064;
            3'h2:    h = 32'h032;
            3'h3:    h = 32'h014;
            3'h4:    h = 32'h00A;
            3'h5:    h = 32'h005;
            default: h = 32'h002;
        endcase
        return (32'(RATE_CYC) * h) >> 1;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Link domain, clocked by scl
    logic [1:0]       lrst_reg = 2'h0;
    logic             oe_reg   = 1'b0;
    logic             oe_next;
    logic             sda_hi_reg;
    logic             start_tgl_reg = 1'b0;
    logic             start_seen_reg, start_ev;
    mmc_lst_t         l_st_reg, l_st_next;
    logic [2:0]       bit_reg, bit_next;
    logic [7:0]       sh_reg, sh_next, tx_reg, tx_next;
    logic [7:0]       ptr_reg, ptr_next;
    logic             rw_reg, rw_next;
    logic [7:0]       cra_reg, cra_next, crb_reg, crb_next;
    logic [7:0]       mode_reg, mode_next;
    mmc_res_t         dout_reg, dout_next;
    logic             cmd_tgl_reg, cmd_tgl_next;
    logic [1:0]       res_s_reg, done_s_reg;
    logic             res_seen_reg, res_seen_next;
    logic             done_seen_reg;
    // Clock domain state read by the link
    mmc_res_t         res_reg, res_next;
    logic             res_tgl_reg, res_tgl_next;
    logic             done_tgl_reg, done_tgl_next;

    // Open drain: only ever pulls low, never drives the clock
    assign sda_out_out = 1'b0;
    assign sda_oe_out  = oe_reg;

    // Bit value seen while scl is high
    always_ff @(posedge scl_in) begin
        sda_hi_reg <= sda_in;
    end

    // START caught on the sda edge: scl stands still between frames,
    // so a STOP then START leaves no scl edge to sample it on
    always_ff @(negedge sda_in) begin
        if (scl_in)
            start_tgl_reg <= ~start_tgl_reg;
    end
    assign start_ev = start_tgl_reg != start_seen_reg;

    // Slave sequencing; a bit is taken at each falling scl edge
    always_comb begin
        l_st_next     = l_st_reg;
        bit_next      = bit_reg + 3'h1;
        sh_next       = {sh_reg[6:0], sda_hi_reg};
        tx_next       = {tx_reg[6:0], 1'b0};
        ptr_next      = ptr_reg;
        rw_next       = rw_reg;
        oe_next       = 1'b0;
        cra_next      = cra_reg;
        crb_next      = crb_reg;
        mode_next     = mode_reg;
        dout_next     = dout_reg;
        cmd_tgl_next  = cmd_tgl_reg;
        res_seen_next = res_seen_reg;
        // Single measurement finished: mode bits go to idle
        if (done_s_reg[1] != done_seen_reg &&
            mode_reg[1:0] == MODE_SINGLE)
            mode_next = {6'h00, MODE_IDLE};
        // No result copy mid-read, so a burst never tears
        if (res_s_reg[1] != res_seen_reg &&
            l_st_reg != L_RD && l_st_reg != L_IDLE) begin
            dout_next     = res_reg;
            res_seen_next = res_s_reg[1];
        end
        case (l_st_reg)
            L_ADDR: begin
                if (bit_reg == 3'h7) begin
                    if (sh_next[7:1] == `MMC_I2C_ADDR) begin
                        l_st_next = L_ACKA;
                        oe_next   = 1'b1;
                        rw_next   = sh_next[0];
                    end else
                        l_st_next = L_IDLE;
                end
            end
            L_ACKA, L_ACKW: begin
                bit_next = 3'h0;
                if (l_st_reg == L_ACKA && rw_reg) begin
                    tx_next = rd_byte(ptr_reg, cra_reg, crb_reg,
                                      mode_reg, dout_next);
                    ptr_next  = nxt_ptr(ptr_reg);
                    oe_next   = ~tx_next[7];
                    l_st_next = L_RD;
                end else
                    l_st_next = (l_st_reg == L_ACKA) ? L_PTR : L_WR;
            end
            L_PTR: begin
                if (bit_reg == 3'h7) begin
                    ptr_next  = sh_next;
                    oe_next   = 1'b1;
                    l_st_next = L_ACKP;
                end
            end
            L_ACKP: begin
                bit_next  = 3'h0;
                l_st_next = L_WR;
            end
            L_WR: begin
                if (bit_reg == 3'h7) begin
                    // Mode and config writes retune the sequencer
                    case (ptr_reg)
                        `MMC_A_CRA:  cra_next  = sh_next;
                        `MMC_A_CRB:  crb_next  = sh_next;
                        `MMC_A_MODE: mode_next = {6'h00, sh_next[1:0]};
                        default:     ;
                    endcase
                    if (ptr_reg <= `MMC_A_MODE)
                        cmd_tgl_next = ~cmd_tgl_reg;
                    ptr_next  = nxt_ptr(ptr_reg);
                    oe_next   = 1'b1;
                    l_st_next = L_ACKW;
                end
            end
            L_RD: begin
                // Ninth bit sampled as master ack; stop on a nack
                if (bit_reg == 3'h0 && tx_reg == 8'h00 && rw_reg) begin
                    l_st_next = L_RD;
                end
                if (bit_reg < 3'h7) begin
                    oe_next = ~tx_next[7];
                end else if (bit_reg == 3'h7) begin
                    rw_next = 1'b0;
                end
                if (!rw_reg) begin
                    bit_next = 3'h0;
                    if (!sda_hi_reg) begin
                        rw_next   = 1'b1;
                        tx_next   = rd_byte(ptr_reg, cra_reg, crb_reg,
                                            mode_reg, dout_reg);
                        ptr_next  = nxt_ptr(ptr_reg);
                        oe_next   = ~tx_next[7];
                    end else begin
                        l_st_next = L_IDLE;        // Nack: let go of sda
                        oe_next   = 1'b0;
                    end
                end
            end
            default: l_st_next = L_IDLE;
        endcase
        // Framing seen as sda moving while scl was high
        if (start_ev) begin
            l_st_next = L_ADDR;
            bit_next  = 3'h0;
            oe_next   = 1'b0;
        end else if (!sda_hi_reg && sda_in && !oe_reg) begin
            l_st_next = L_IDLE;
            oe_next   = 1'b0;
        end
    end

    // Link registers; reset caught from the system reset
    always_ff @(negedge scl_in) begin
        lrst_reg   <= {lrst_reg[0], rst_n_in};
        res_s_reg  <= {res_s_reg[0], res_tgl_reg};
        done_s_reg <= {done_s_reg[0], done_tgl_reg};
        start_seen_reg <= start_tgl_reg;
        if (!lrst_reg[1]) begin
            oe_reg        <= 1'b0;
            l_st_reg      <= L_IDLE;
            bit_reg       <= 3'h0;
            sh_reg        <= 8'h00;
            tx_reg        <= 8'h00;
            ptr_reg       <= 8'h00;
            rw_reg        <= 1'b0;
            cra_reg       <= `MMC_CRA_RST;
            crb_reg       <= `MMC_CRB_RST;
            mode_reg      <= `MMC_MODE_RST;
            dout_reg      <= '0;
            cmd_tgl_reg   <= 1'b0;
            res_seen_reg  <= res_s_reg[1];
            done_seen_reg <= done_s_reg[1];
        end else begin
            oe_reg        <= oe_next;
            l_st_reg      <= l_st_next;
            bit_reg       <= bit_next;
            sh_reg        <= sh_next;
            tx_reg        <= tx_next;
            ptr_reg       <= ptr_next;
            rw_reg        <= rw_next;
            cra_reg       <= cra_next;
            crb_reg       <= crb_next;
            mode_reg      <= mode_next;
            dout_reg      <= dout_next;
            cmd_tgl_reg   <= cmd_tgl_next;
            res_seen_reg  <= res_seen_next;
            done_seen_reg <= done_s_reg[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Measurement sequencer on the internal clock
    logic [1:0]              cmd_s_reg;
    logic                    cmd_seen_reg, cmd_ev;
    mmc_cfg_t                cfg_reg, cfg_next;
    mmc_mst_t                st_reg, st_next;
    logic [31:0]             tmr_reg, tmr_next, per_reg, per_next;
    logic [31:0]             data_ready_n_reg, data_ready_n_next;
    logic [1:0]              axis_reg, axis_next;
    logic [2:0][`MMC_DW-1:0] set_reg, set_next, dif_reg, dif_next;
    logic                    req_reg, req_next, dr_n_reg;
    logic                    sp_reg, sd_reg, bp_reg, bn_reg, busy;

    assign cmd_ev               = cmd_s_reg[1] != cmd_seen_reg;
    assign conv_req_out         = req_reg;
    assign conv_axis_out        = axis_reg;
    assign strap_pos_node_out   = sp_reg;
    assign strap_drive_node_out = sd_reg;
    assign bias_pos_out         = bp_reg;
    assign bias_neg_out         = bn_reg;
    assign data_ready_n_out     = dr_n_reg;

    // Next state; timing counts only on clk_in
    always_comb begin
        st_next       = st_reg;
        tmr_next      = (tmr_reg == 32'h0) ? 32'h0 : tmr_reg - 32'h1;
        per_next      = (per_reg == 32'h0) ? 32'h0 : per_reg - 32'h1;
        data_ready_n_next     = (data_ready_n_reg == 32'h0) ? 32'h0 : data_ready_n_reg - 32'h1;
        axis_next     = axis_reg;
        req_next      = 1'b0;
        cfg_next      = cfg_reg;
        set_next      = set_reg;
        dif_next      = dif_reg;
        res_next      = res_reg;
        res_tgl_next  = res_tgl_reg;
        done_tgl_next = done_tgl_reg;
        // Words are stable: written on the same scl edge as the toggle, seen only after its two-flop sync
        if (cmd_ev)
            cfg_next = '{mode: mode_reg[1:0], ms: cra_reg[1:0],
                         rate: cra_reg[4:2]};
        case (st_reg)
            M_IDLE, M_WAIT: begin
                if (cfg_next.mode[1])
                    st_next = M_IDLE;
                else if (cmd_ev || (st_reg == M_WAIT && per_reg == 0)) begin
                    st_next  = M_SET;
                    tmr_next = 32'(`MMC_STRAP_CYC);
                    per_next = rate_cyc(cfg_next.rate);
                end
            end
            M_SET, M_RST: begin
                if (tmr_reg == 32'h1) begin
                    st_next   = (st_reg == M_SET) ? M_CS : M_CR;
                    axis_next = 2'h0;
                    req_next  = 1'b1;
                end
            end
            M_CS, M_CR: begin
                if (conv_valid_in) begin
                    if (st_reg == M_CS)
                        set_next[axis_reg] = conv_data_in;
                    else
                        dif_next[axis_reg] = half_dif(set_reg[axis_reg],
                                                      conv_data_in);
                    if (axis_reg == 2'h2) begin
                        st_next  = (st_reg == M_CS) ? M_RST : M_WRITE;
                        tmr_next = 32'(`MMC_STRAP_CYC);
                    end else begin
                        axis_next = axis_reg + 2'h1;
                        req_next  = 1'b1;
                    end
                end
            end
            M_WRITE: begin
                // All three axes land at once, with data-ready on the same edge
                res_next     = '{ax: dif_reg};
                res_tgl_next = ~res_tgl_reg;
                data_ready_n_next    = 32'(DATA_READY_N_CYC);
                st_next      = M_WAIT;
                if (cfg_reg.mode == MODE_SINGLE && !cmd_ev) begin
                    done_tgl_next = ~done_tgl_reg;
                    cfg_next.mode = MODE_IDLE;
                    st_next       = M_IDLE;
                end
            end
            default: st_next = M_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_in) begin
        cmd_s_reg <= {cmd_s_reg[0], cmd_tgl_reg};
        if (!rst_n_in) begin
            cmd_seen_reg <= 1'b0;
            cfg_reg      <= '{mode: MODE_SINGLE, ms: MS_NORM,
                              rate: 3'(`MMC_CRA_RST >> 2)};
            st_reg       <= M_IDLE;
            tmr_reg      <= 32'h0;
            per_reg      <= 32'h0;
            data_ready_n_reg     <= 32'h0;
            axis_reg     <= 2'h0;
            set_reg      <= '0;
            dif_reg      <= '0;
            res_reg      <= '0;
            res_tgl_reg  <= 1'b0;
            done_tgl_reg <= 1'b0;
            req_reg      <= 1'b0;
            dr_n_reg     <= 1'b1;
            sp_reg       <= 1'b0;
            sd_reg       <= 1'b0;
            bp_reg       <= 1'b0;
            bn_reg       <= 1'b0;
        end else begin
            cmd_seen_reg <= cmd_s_reg[1];
            cfg_reg      <= cfg_next;
            st_reg       <= st_next;
            tmr_reg      <= tmr_next;
            per_reg      <= per_next;
            data_ready_n_reg     <= data_ready_n_next;
            axis_reg     <= axis_next;
            set_reg      <= set_next;
            dif_reg      <= dif_next;
            res_reg      <= res_next;
            res_tgl_reg  <= res_tgl_next;
            done_tgl_reg <= done_tgl_next;
            req_reg      <= req_next;
            dr_n_reg     <= (data_ready_n_next == 32'h0);
            sp_reg       <= (st_next == M_SET);
            sd_reg       <= (st_next == M_RST);
            bp_reg       <= busy && cfg_next.ms == MS_POS;
            bn_reg       <= busy && cfg_next.ms == MS_NEG;
        end
    end
    assign busy = st_next != M_IDLE && st_next != M_WAIT;

    ////////////////////////////////////////////////////////////////////
    // Checks on the sequencer
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_data_ready_n_fall;
        $fell(data_ready_n_out) |-> $past(st_reg) == M_WRITE;
    endproperty
    a_data_ready_n_fall: assert property (p_data_ready_n_fall)
        else $error("data ready fell without a result");
    property p_data_ready_n_len;
        $rose(data_ready_n_out) |-> $past(data_ready_n_reg) == 32'h1;
    endproperty
    a_data_ready_n_len: assert property (p_data_ready_n_len)
        else $error("data ready low time wrong");
    property p_set_pulse;
        $rose(strap_pos_node_out) |-> strap_pos_node_out[*2]
            ##1 !strap_drive_node_out;
    endproperty
    a_set_pulse: assert property (p_set_pulse)
        else $error("set pulse too short");
    property p_half;
        st_reg == M_CR && conv_valid_in && axis_reg == 2'h1 |=>
            {dif_reg[1], 1'b0} == (17'({$past(set_reg[1][15]),
                $past(set_reg[1])} - {$past(conv_data_in[15]),
                $past(conv_data_in)}) & 17'h1FFFE);
    endproperty
    a_half: assert property (p_half)
        else $error("axis result is not half the difference");
    property p_bias;
        !(bias_pos_out && bias_neg_out) and
        (bias_pos_out |-> cfg_reg.ms == MS_POS);
    endproperty
    a_bias: assert property (p_bias)
        else $error("self test bias does not match configuration");
    property p_single_idle;
        st_reg == M_WRITE && cfg_reg.mode == MODE_SINGLE && !cmd_ev |=>
            st_reg == M_IDLE && done_tgl_reg != $past(done_tgl_reg);
    endproperty
    a_single_idle: assert property (p_single_idle)
        else $error("single measurement did not return to idle");
    property p_cont_rate;
        st_reg == M_WAIT && per_reg == 32'h0 && !cfg_reg.mode[1] &&
            !cmd_ev |=> st_reg == M_SET;
    endproperty
    a_cont_rate: assert property (p_cont_rate)
        else $error("continuous measurement not restarted");
    property p_publish;
        res_tgl_reg != $past(res_tgl_reg) |-> $past(st_reg) == M_WRITE
            && res_reg == $past(dif_reg);
    endproperty
    a_publish: assert property (p_publish)
        else $error("results published outside the write step");
endmodule

// [verification/mmc_host_model.sv]
// Purpose: I2C master model on the sensor link
// Assumes: open-drain SDA with a pull-up
// Notes: SCL stands high between frames
`timescale 1ns/100ps
module mmc_host_model (
    // Link wires
    input  wire logic dev_oe_in,
    output logic      scl_out,
    output logic      sda_out
);
    logic       drv_low = 1'h0;
    logic       x;
    logic [7:0] rb [8];
    // Pull-up wins unless a party pulls low
    assign sda_out = !(drv_low || dev_oe_in);
    initial scl_out = 1'h1;
    // Data moves only while SCL is low; the master owns SCL
    task automatic bt(input logic b, output logic r);
        drv_low = !b;
        #3 scl_out = 1'h1;
        #3 r = sda_out;
        #3 scl_out = 1'h0;
        #3;
    endtask
    task automatic by(input logic [7:0] t, input logic a,
                      output logic [7:0] r, output logic k);
        for (int i = 7; i >= 0; i--) bt(t[i], r[i]);
        bt(a, k);
    endtask
    // Idle pulses so the link side sees reset
    task automatic pulses();
        repeat (2) bt(1'h1, x);
        scl_out = 1'h1;
    endtask
    // START, address, body, STOP; a read NACKs its last byte
    task automatic fr(input logic [7:0] a8, p, input int n,
                      input logic [7:0] d, output logic k);
        logic [7:0] r;
        #3 drv_low = 1'h1;
        #3 scl_out = 1'h0;
        by(a8, 1'h1, r, k);
        if (!a8[0]) by(p, 1'h1, r, x);
        for (int i = 0; i < n; i++)
            if (a8[0]) by(8'hFF, i == n - 1, rb[i], x);
            else by(d, 1'h1, r, x);
        drv_low = 1'h1;
        #3 scl_out = 1'h1;
        #3 drv_low = 1'h0;
        #3;
    endtask
endmodule

// [verification/tb_magnetometer_measurement_ctrl.sv]
// Purpose: self-checking bench of the measurement control
// Assumes: front end modelled here, host model on the link
// Notes: short data-ready and rate counts keep the run brief
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    num_errors++; $display("unexpected %0t: %h not %h", $time, a, e); end end
module tb_magnetometer_measurement_ctrl;
    // Rows: config bits, set and reset readings, Y first
    typedef struct packed {logic [1:0] ms; logic [2:0][15:0] s, r;} mmc_row_t;
    mmc_row_t rows [3] = '{'{2'h0, 48'h0100_FFF0_0040, 48'h0020_0010_FFC0},
        '{2'h1, 48'h7FF0_8010_1234, 48'h8010_7FF0_0234},
        '{2'h2, 48'h0001_FFFF_0003, 48'h0}};
    logic clk_in = 1'h0, rst_n_in = 1'h0, conv_valid_in = 1'h0, sen, ph;
    logic scl, sda, oe, sp, sd, bpo, bno, req, data_ready_n_n, bp, bn, ak, pv, so, rq;
    logic [1:0]       ax, q;
    logic [15:0]      conv_data_in = 16'h0000;
    logic [16:0]      d;
    logic [2:0][15:0] ex;
    mmc_row_t         cur;
    int               num_errors = 0, total_checks = 0, n;
    mmc_top #(.DATA_READY_N_CYC(20), .RATE_CYC(200)) i_dut (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda), .sda_out_out(so),
        .sda_oe_out(oe), .strap_pos_node_out(sp), .strap_drive_node_out(sd),
        .bias_pos_out(bpo), .bias_neg_out(bno), .conv_req_out(req),
        .conv_axis_out(ax), .conv_valid_in(conv_valid_in),
        .conv_data_in(conv_data_in), .data_ready_n_out(data_ready_n_n));
    mmc_host_model h (.dev_oe_in(oe), .scl_out(scl), .sda_out(sda));
    always #5 clk_in = ~clk_in;
    // Front end answers a cycle after each request; stalls while sen low
    always @(posedge clk_in) begin
        rq = req;
        q = ax;
        if (sp) ph = 1'h1;
        if (sd) ph = 1'h0;
        if (req) {bp, bn} = {bp | bpo, bn | bno};
        #1 conv_valid_in = rq && sen;
        conv_data_in = !conv_valid_in ? ~conv_data_in :
                       ph ? cur.s[q] : cur.r[q];
    end
    // Counts data-ready falling edges over c cycles
    task automatic falls(input int c, output int k);
        k = 0;
        repeat (c) begin
            pv = data_ready_n_n;
            @(posedge clk_in) #1;
            if (pv === 1'h1 && data_ready_n_n === 1'h0) k++;
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {sen, ph, bp, bn} = 4'h0;
        h.pulses();
        repeat (8) @(posedge clk_in);
        #1 rst_n_in = 1'h1;
        `CHK(data_ready_n_n, 1'h1)
        h.pulses();
        h.fr(8'h3C, 8'h02, 0, 8'h00, ak);
        h.fr(8'h3D, 8'h00, 1, 8'h00, ak);
        `CHK(h.rb[0], 8'h01)
        sen = 1'h1;
        repeat (400) @(posedge clk_in);
        foreach (rows[i]) begin
            cur = rows[i];
            {bp, bn} = 2'h0;
            h.fr(8'h3C, 8'h00, 1, {6'h1C, cur.ms}, ak);
            h.fr(8'h3C, 8'h02, 1, 8'h01, ak);
            `CHK(ak, 1'h0)
            n = 0;
            for (int t = 0; data_ready_n_n !== 1'h0 && t < 3000; t++)
                @(posedge clk_in) #1;
            while (data_ready_n_n === 1'h0 && n < 99) @(posedge clk_in) #1 n++;
            `CHK(n, 20)
            h.fr(8'h3C, 8'h03, 0, 8'h00, ak);
            h.fr(8'h3D, 8'h00, 6, 8'h00, ak);
            for (int k = 0; k < 3; k++) begin
                d = {cur.s[k][15], cur.s[k]} - {cur.r[k][15], cur.r[k]};
                ex[k] = d[16:1];
                `CHK({h.rb[2*k], h.rb[2*k+1]}, ex[k])
            end
            `CHK({bp, bn}, {cur.ms == 2'h1, cur.ms == 2'h2})
            h.fr(8'h3C, 8'h02, 0, 8'h00, ak);
            h.fr(8'h3D, 8'h00, 1, 8'h00, ak);
            `CHK(h.rb[0], 8'h03)
        end
        h.fr(8'h3C, 8'h08, 0, 8'h00, ak);
        h.fr(8'h3D, 8'h00, 2, 8'h00, ak);
        `CHK({h.rb[0], h.rb[1]}, {ex[2][7:0], ex[0][15:8]})
        h.fr(8'h3E, 8'h02, 1, 8'h00, ak);
        `CHK(ak, 1'h1)
        `CHK(so, 1'h0)
        h.fr(8'h3C, 8'h02, 1, 8'h00, ak);
        falls(2200, n);
        `CHK(n >= 2, 1'h1)
        h.fr(8'h3C, 8'h02, 1, 8'h03, ak);
        repeat (300) @(posedge clk_in);
        falls(400, n);
        `CHK(n, 0)
        give_verdict();
    end
    // Watchdog well past the expected run length
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule
